/* File: bench/drs_ctrl_chk.sv */
// pin timing checks for the strobe controller
// bound into drs_ctrl; sees its ports only
module drs_ctrl_chk #(
   parameter int PWRUP_CYC = 10,
   parameter int RFSH_EVERY = 200
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic reqReady,
   input wire logic rspValid,
   input wire logic initDone,
   input wire logic rasN,
   input wire logic casN,
   input wire logic weN,
   input wire logic [drs_pkg::ADDR_W-1:0] addr,
   input wire logic dataIn
);
   import drs_pkg::*;
   localparam logic [7:0] COL_CYC = 8'(COL_ACCESS_NS / CLK_PERIOD_NS);
   logic [7:0] casRun;
   logic [3:0] rasCnt;
   logic [15:0] cbrGap;
   // cycles since column fall, row falls seen, cycles since refresh
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         casRun <= 8'h00;
         rasCnt <= 4'h0;
         cbrGap <= 16'h0000;
      end else begin
         casRun <= $fell(casN) ? 8'h01 : casRun + 8'(casRun != 8'hff);
         rasCnt <= rasCnt + 4'($fell(rasN) && rasCnt != 4'hf);
         cbrGap <= ($fell(rasN) && !casN) ? 16'h0000 : cbrGap + 16'(cbrGap != 16'hffff);
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   row_addr_a: assert property ($fell(rasN) && casN |-> $stable(addr))
      else $error("row address moved at row fall");
   col_hold_a: assert property ($fell(casN) && !rasN |-> ##1 $stable(addr) [*4])
      else $error("column address not held");
   we_hold_a: assert property (
      $fell(casN) && !rasN |-> ##1 $stable(weN) [*4])
      else $error("write enable moved near column fall");
   data_hold_a: assert property (
      $fell(casN) && !rasN && !weN |-> ##1 $stable(dataIn) [*4])
      else $error("write data not held");
   rmw_hold_a: assert property ($fell(weN) && !casN |-> ##1 $stable(dataIn) [*4])
      else $error("late write data not held");
   cbr_setup_a: assert property ($fell(casN) && rasN |-> ##[6:60] $fell(rasN))
      else $error("refresh row fall out of window");
   access_time_a: assert property (rspValid |-> casRun >= COL_CYC)
      else $error("data sampled too early");
   init_seq_a: assert property ($rose(initDone) |-> rasCnt >= 4'h8)
      else $error("ready before eight row cycles");
   ready_init_a: assert property (reqReady |-> initDone)
      else $error("request accepted before init");
   refresh_gap_a: assert property (initDone |-> cbrGap <= 16'(RFSH_EVERY + 250))
      else $error("refresh interval exceeded");
   cover property ($fell(weN) && !casN && !rasN);
   cover property ($fell(rasN) && !casN && initDone);
   cover property (rspValid);
endmodule
bind drs_ctrl drs_ctrl_chk #(.PWRUP_CYC(PWRUP_CYC), .RFSH_EVERY(RFSH_EVERY)) u_chk (
   .core_clk(core_clk), .rst_n(rst_n), .reqReady(reqReady), .rspValid(rspValid),
   .initDone(initDone), .rasN(rasN), .casN(casN), .weN(weN), .addr(addr), .dataIn(dataIn));

/* File: bench/drs_mem_model.sv */
// behavioural 256k x 1 dynamic memory on the strobe pins
// strobes come from the controller; an undriven output shows the inverse
module drs_mem_model (
   input wire logic rasN,
   input wire logic casN,
   input wire logic weN,
   input wire logic [drs_pkg::ADDR_W-1:0] addr,
   input wire logic dataIn,
   output logic dataOut
);
   timeunit 1ns;
   timeprecision 1ps;
   import drs_pkg::*;
   logic mem [0:262143];
   logic [8:0] row, col;
   logic [7:0] cnt = 8'h00;
   logic [17:0] tstAddr = 18'h00000;
   logic cbr = 1'h0, drv = 1'h0, q = 1'h0;
   int rowOpens = 0, refreshes = 0;
   // row fall: latch the row or run a counter refresh
   always @(negedge rasN) begin
      cbr = !casN;
      if (cbr) refreshes++;
      else rowOpens++;
      if (!cbr) row = addr;
   end
   // counter steps once each internal refresh ends
   always @(posedge rasN) if (cbr) cnt++;
   // gated column fall: column latch, test row, early write or read
   always @(negedge casN) if (!rasN) begin
      col = addr;
      if (cbr) row = {1'h1, cnt};
      if (cbr) tstAddr = {row, col};
      q = mem[{row, col}];
      if (!weN) mem[{row, col}] = dataIn;
      else #(COL_ACCESS_NS) drv = !casN;
   end
   // output released when the column strobe rises
   always @(posedge casN) drv = 1'h0;
   // late write-enable fall strobes data-in, output keeps old bit
   always @(negedge weN) begin
      if (!casN && !rasN) mem[{row, col}] = dataIn;
   end
   assign dataOut = drv ? q : ~q;
endmodule

/* File: bench/testbench.sv */
// bench top: clock, reset, scenarios and the verdict
// drives drs_ctrl with short counts against the memory model
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import drs_pkg::*;
   localparam int RFSH = 200;
   localparam logic [8:0] PTS [4] = '{9'h000, 9'h1ff, 9'h0aa, 9'h155};
   logic core_clk = 1'h0, rst_n = 1'h0, reqValid = 1'h0, reqData = 1'h0, reqPage = 1'h0;
   logic [1:0] reqCmd = 2'h0;
   logic [ADDR_W-1:0] reqRow = 9'h000, reqCol = 9'h000, addr;
   logic reqReady, rspValid, rspData, initDone, rasN, casN, weN, dataIn, dataOut, rd;
   int err_total = 0, checks_done = 0, cyc = 0;
   drs_ctrl #(.PWRUP_CYC(10), .RFSH_EVERY(RFSH)) DUT (.core_clk(core_clk), .rst_n(rst_n),
      .reqValid(reqValid), .reqCmd(reqCmd), .reqRow(reqRow), .reqCol(reqCol),
      .reqData(reqData), .reqPage(reqPage), .reqReady(reqReady), .rspValid(rspValid),
      .rspData(rspData), .initDone(initDone), .rasN(rasN), .casN(casN), .weN(weN),
      .addr(addr), .dataIn(dataIn), .dataOut(dataOut));
   drs_mem_model u_mem (.rasN(rasN), .casN(casN), .weN(weN), .addr(addr), .dataIn(dataIn),
      .dataOut(dataOut));
   // clock and hang guard
   initial forever #2.5 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 10000) begin
         err_total++;
         print_verdict();
      end
   end
   task automatic print_verdict();
      if (err_total == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic check(input string what, input logic [17:0] s, input logic [17:0] e);
      checks_done++;
      if (s !== e) begin
         err_total++;
         $display("FAIL %s expected %h seen %h", what, e, s);
      end
   endtask
   // one request held until taken; page leaves it raised
   task automatic req(input logic [1:0] c, input logic [8:0] r, input logic [8:0] k,
         input logic d, input logic p);
      int n;
      @(negedge core_clk);
      reqValid = 1'h1;
      reqCmd = c;
      reqRow = r;
      reqCol = k;
      reqData = d;
      reqPage = p;
      for (n = 0; n < 500 && reqReady !== 1'h1; n++) @(negedge core_clk);
      @(negedge core_clk);
      reqValid = p;
   endtask
   // wait for the read answer
   task automatic get();
      int n;
      for (n = 0; n < 500 && rspValid !== 1'h1; n++) @(negedge core_clk);
      rd = rspData;
      if (n == 500) check("answer", 18'h0, 18'h1);
   endtask
   // power-up: only counter refreshes before ready
   task automatic t_init();
      for (int n = 0; n < 3000 && initDone !== 1'h1; n++) @(negedge core_clk);
      check("init done", 18'(initDone), 18'h1);
      check("init refreshes", 18'(u_mem.refreshes), 18'h8);
      check("init rows", 18'(u_mem.rowOpens), 18'h0);
      check("counter", 18'(u_mem.cnt), 18'h8);
   endtask
   // addresses from patterns 000, 1ff, 0aa, 155 (row i, column 3-i) written, then read with opposite data-in
   task automatic t_wrrd();
      for (int i = 0; i < 4; i++) req(CMD_WRITE, PTS[i], PTS[3-i], 1'(i), 1'h0);
      for (int i = 0; i < 4; i++) begin
         req(CMD_READ, PTS[i], PTS[3-i], ~1'(i), 1'h0);
         get();
         check("read", 18'(rd), 18'(i % 2));
         check("cell", 18'(u_mem.mem[{PTS[i], PTS[3-i]}]), 18'(i % 2));
      end
   endtask
   // read-modify-write returns old bit, stores new one
   task automatic t_rmw();
      req(CMD_WRITE, 9'h012, 9'h034, 1'h0, 1'h0);
      req(CMD_RMW, 9'h012, 9'h034, 1'h1, 1'h0);
      get();
      check("rmw old", 18'(rd), 18'h0);
      req(CMD_READ, 9'h012, 9'h034, 1'h0, 1'h0);
      get();
      check("rmw new", 18'(rd), 18'h1);
   endtask
   // two writes in one row period, then a normal read; starts just after a refresh
   // so that no refresh falls due at the page boundary and closes the row
   task automatic t_page();
      int r0, f0;
      f0 = u_mem.refreshes;
      wait (u_mem.refreshes != f0);
      r0 = u_mem.rowOpens;
      req(CMD_WRITE, 9'h0f0, 9'h001, 1'h1, 1'h1);
      req(CMD_WRITE, 9'h0f0, 9'h002, 1'h0, 1'h0);
      req(CMD_READ, 9'h0f0, 9'h001, 1'h0, 1'h0);
      get();
      check("page opens", 18'(u_mem.rowOpens - r0), 18'h2);
      check("page read", 18'(rd), 18'h1);
      check("page cell", 18'(u_mem.mem[{9'h0f0, 9'h002}]), 18'h0);
   endtask
   // counter test access lands on the test row
   task automatic t_test();
      req(CMD_TEST, 9'h000, 9'h0c3, 1'h1, 1'h0);
      get();
      check("test row8", 18'(u_mem.tstAddr[17]), 18'h1);
      check("test col", 18'(u_mem.tstAddr[8:0]), 18'h0c3);
      check("test cell", 18'(u_mem.mem[u_mem.tstAddr]), 18'h1);
   endtask
   // idle time still sees periodic refreshes
   task automatic t_rfsh();
      int r0;
      r0 = u_mem.refreshes;
      repeat (5 * RFSH) @(negedge core_clk);
      check("refresh", 18'(u_mem.refreshes - r0 >= 4), 18'h1);
   endtask
   // reset, scenarios, verdict
   initial begin
      repeat (8) @(negedge core_clk);
      rst_n = 1'h1;
      t_init();
      t_wrrd();
      t_rmw();
      t_page();
      t_test();
      t_rfsh();
      print_verdict();
   end
endmodule

/* File: hw/drs_ctrl.sv */
// controller that drives a 256k x 1 dynamic memory through its strobe pins
// assumes synchronous inputs on core_clk; pin levels are active-low strobes
// Notes on behaviour
// [RULE1] cell picked by 9 row bits at row fall, 9 column bits at column fall
// [RULE2] row address placed on the pins before the row strobe falls
// [RULE3] column strobe only used once the row strobe is low
// [RULE4] write-enable high reads, low writes; data-in ignored on reads
// [RULE5] data-in captured at the later of column strobe or write-enable fall
// [RULE6] write-enable low before column fall gives an early write, output off
// [RULE7] write-enable falling late after column fall gives a read-write cycle
// [RULE8] write-enable timing between the two cases leaves output undefined
// [RULE9] output off until column strobe low; write cycles carry no data
// [RULE10] read data valid after row access or column access time
// [RULE11] read data held until column strobe returns high
// [RULE12] page mode keeps row strobe low over several column accesses
// [RULE13] hold times counted from column strobe or write-enable only
// [RULE14] all 256 rows refreshed within every 4 ms
// [RULE15] row-only cycle refreshes a row, output stays off
// [RULE16] column low before row fall starts internal counter refresh
// [RULE17] device counter advances after each internal refresh
// [RULE18] column held low after read, row cycled: hidden refresh keeps data
// [RULE19] column rise and fall during internal refresh opens a test access
// [RULE20] test row from counter with bit 8 high; column from second fall
// [RULE21] counter test: 8 init cycles, write, modify, read, complemented
// [RULE22] wait 100 us, then 8 row cycles before normal accesses
// [RULE23] read-modify-write reads at column fall, writes at later we fall
module drs_ctrl
   import drs_pkg::*;
#(
   parameter int PWRUP_CYC = PWRUP_DEF,
   parameter int RFSH_EVERY = RFSH_EVERY_DEF
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic reqValid,
   input wire logic [1:0] reqCmd,
   input wire logic [ADDR_W-1:0] reqRow,
   input wire logic [ADDR_W-1:0] reqCol,
   input wire logic reqData,
   input wire logic reqPage,
   output logic reqReady,
   output logic rspValid,
   output logic rspData,
   output logic initDone,
   output logic rasN,
   output logic casN,
   output logic weN,
   output logic [ADDR_W-1:0] addr,
   output logic dataIn,
   input wire logic dataOut
);
   import drs_pkg::*;

   typedef struct packed {
      drs_state_t st;
      logic [CNT_W-1:0] tmr;
      logic [31:0] rfshTmr;
      logic [19:0] pwrTmr;
      logic [3:0] initCnt;
      logic rfshPend;
      logic [1:0] cmd;
      logic [ADDR_W-1:0] col;
      logic wdat;
      logic page;
      logic hidden;
      logic reqReady;
      logic rspValid;
      logic rspData;
      logic initDone;
      logic rasN;
      logic casN;
      logic weN;
      logic [ADDR_W-1:0] addr;
      logic dataIn;
   } drs_regs_t;

   drs_regs_t s_q, s_d;
   logic tmrDone;

   assign tmrDone = (s_q.tmr == '0);

   // next-state logic for the whole controller
   always_comb begin
      s_d = s_q;
      s_d.rspValid = 1'b0;
      s_d.reqReady = 1'b0;
      if (!tmrDone) begin
         s_d.tmr = s_q.tmr - 1'b1;
      end
      // refresh pacing, one row every interval slice
      if (s_q.initDone) begin
         if (s_q.rfshTmr >= 32'(RFSH_EVERY - 1)) begin
            s_d.rfshTmr = '0;
            s_d.rfshPend = 1'b1; // see [RULE14]
         end else begin
            s_d.rfshTmr = s_q.rfshTmr + 32'h1;
         end
      end
      unique case (s_q.st)
         ST_PWRUP: begin
            if (s_q.pwrTmr >= 20'(PWRUP_CYC)) begin
               s_d.st = ST_CBR; // see [RULE22]
               s_d.casN = 1'b0;
               s_d.tmr = FCS_CYC;
               s_d.initCnt = INIT_CNT;
            end else begin
               s_d.pwrTmr = s_q.pwrTmr + 20'h1;
            end
         end
         ST_IDLE: begin
            s_d.reqReady = !s_q.rfshPend;
            // a ready already shown is honoured ahead of a refresh that just fell due
            if (reqValid && s_q.reqReady && tmrDone) begin
               s_d.reqReady = 1'b0;
               s_d.cmd = reqCmd;
               s_d.col = reqCol;
               s_d.wdat = reqData;
               s_d.page = reqPage;
               s_d.dataIn = reqData;
               if (reqCmd == CMD_TEST) begin
                  s_d.casN = 1'b0; // see [RULE19]
                  s_d.tmr = FCS_CYC;
                  s_d.st = ST_CBR;
               end else begin
                  s_d.addr = reqRow; // see [RULE2]
                  s_d.weN = (reqCmd != CMD_WRITE); // see [RULE6]
                  s_d.st = ST_ROW;
               end
            end else if (s_q.rfshPend && tmrDone) begin
               s_d.casN = 1'b0; // see [RULE16]
               s_d.tmr = FCS_CYC;
               s_d.st = ST_CBR;
            end
         end
         ST_ROW: begin
            s_d.rasN = 1'b0; // see [RULE1]
            s_d.tmr = (ROW_HOLD_CYC > RCD_CYC) ? ROW_HOLD_CYC : RCD_CYC;
            s_d.st = ST_COL;
         end
         ST_COL: begin
            // column address leaves a cycle ahead of the strobe, never with it
            if (s_q.tmr <= CNT_W'(1)) begin
               s_d.addr = s_q.col; // see [RULE3]
            end
            if (tmrDone) begin
               s_d.casN = 1'b0; // see [RULE1]
               s_d.tmr = (s_q.cmd == CMD_RMW) ? CWD_CYC : ACCESS_CYC; // see [RULE10]
               s_d.st = ST_ACC;
            end
         end
         ST_ACC: begin
            if (tmrDone) begin
               if (s_q.cmd == CMD_WRITE) begin
                  s_d.st = ST_END; // see [RULE9]
                  s_d.tmr = CAS_CYC;
               end else begin
                  s_d.rspValid = 1'b1; // see [RULE11]
                  s_d.rspData = dataOut;
                  if (s_q.cmd == CMD_RMW) begin
                     s_d.weN = 1'b0; // see [RULE7]
                     s_d.dataIn = s_q.wdat; // see [RULE5]
                     s_d.tmr = HOLD_CYC; // see [RULE13]
                     s_d.st = ST_WR;
                  end else begin
                     s_d.st = ST_END;
                     s_d.tmr = '0;
                  end
               end
            end
         end
         ST_WR: begin
            if (tmrDone) begin
               s_d.st = ST_END; // see [RULE23]
               s_d.tmr = '0;
            end
         end
         ST_END: begin
            if (tmrDone) begin
               s_d.weN = 1'b1;
               if (s_q.cmd == CMD_READ && s_q.rfshPend) begin
                  s_d.rasN = 1'b1; // see [RULE18]
                  s_d.hidden = 1'b1;
                  s_d.tmr = PRE_CYC;
                  s_d.st = ST_CBR;
               end else if (s_q.page && reqValid && reqCmd != CMD_TEST
                            && reqCmd != CMD_RMW && !s_q.rfshPend) begin
                  s_d.casN = 1'b1; // see [RULE12]
                  s_d.cmd = reqCmd;
                  s_d.col = reqCol;
                  s_d.wdat = reqData;
                  s_d.dataIn = reqData;
                  s_d.page = reqPage;
                  s_d.weN = (reqCmd != CMD_WRITE);
                  s_d.reqReady = 1'b1;
                  s_d.tmr = CPT_CYC;
                  s_d.st = ST_COL;
               end else begin
                  s_d.casN = 1'b1;
                  s_d.rasN = 1'b1;
                  s_d.tmr = PRE_CYC;
                  s_d.st = ST_PRE;
               end
            end
         end
         ST_PRE: begin
            s_d.weN = 1'b1;
            if (tmrDone) begin
               s_d.st = ST_IDLE;
            end
         end
         ST_CBR: begin
            if (tmrDone) begin
               s_d.rasN = 1'b0; // see [RULE16]
               s_d.tmr = (s_q.cmd == CMD_TEST && s_q.initDone) ? FCH_CYC : RAS_CYC;
               s_d.st = ST_CBRH;
            end
         end
         ST_CBRH: begin
            if (tmrDone) begin
               if (s_q.cmd == CMD_TEST && s_q.initDone) begin
                  s_d.casN = 1'b1; // see [RULE19]
                  s_d.addr = s_q.col; // see [RULE20]
                  s_d.cmd = CMD_RMW;
                  s_d.weN = 1'b1;
                  s_d.tmr = CPT_CYC;
                  s_d.st = ST_TCP;
               end else begin
                  s_d.rasN = 1'b1;
                  s_d.casN = 1'b1;
                  s_d.hidden = 1'b0; // see [RULE17]
                  s_d.rfshPend = s_q.initDone && (s_q.rfshTmr >= 32'(RFSH_EVERY - 1)); // tick wins
                  s_d.tmr = PRE_CYC;
                  s_d.st = s_q.initDone ? ST_PRE : ST_INIT;
               end
            end
         end
         ST_TCP: begin
            if (tmrDone) begin
               s_d.casN = 1'b0; // see [RULE20]
               s_d.tmr = CWD_CYC;
               s_d.page = 1'b0;
               s_d.st = ST_ACC; // see [RULE21]
            end
         end
         ST_INIT: begin
            if (tmrDone) begin
               if (s_q.initCnt <= 4'h1) begin
                  s_d.initDone = 1'b1; // see [RULE22]
                  s_d.st = ST_IDLE;
               end else begin
                  s_d.initCnt = s_q.initCnt - 4'h1;
                  s_d.casN = 1'b0;
                  s_d.tmr = FCS_CYC;
                  s_d.st = ST_CBR;
               end
            end
         end
         default: begin
            s_d.st = ST_IDLE;
         end
      endcase
   end

   // state register
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
         s_q.st <= ST_PWRUP;
         s_q.rasN <= 1'b1;
         s_q.casN <= 1'b1;
         s_q.weN <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // outputs straight from the state flops
   assign reqReady = s_q.reqReady;
   assign rspValid = s_q.rspValid;
   assign rspData = s_q.rspData;
   assign initDone = s_q.initDone;
   assign rasN = s_q.rasN;
   assign casN = s_q.casN;
   assign weN = s_q.weN;
   assign addr = s_q.addr;
   assign dataIn = s_q.dataIn;
endmodule

/* File: hw/drs_pkg.sv */
// package for the dram strobe controller: command codes, states, timing counts
// assumes a 200 MHz core clock
package drs_pkg;
   localparam int CLK_PERIOD_NS = 5;
   localparam int ADDR_W = 9;
   localparam int ROW_HOLD_NS = 15;
   localparam int RCD_NS = 25;
   localparam int ROW_ACCESS_NS = 150;
   localparam int COL_ACCESS_NS = 75;
   localparam int COL_HOLD_NS = 25;
   localparam int CWD_NS = 25;
   localparam int CAS_WIDTH_NS = 75;
   localparam int RAS_WIDTH_NS = 150;
   localparam int RAS_PRE_NS = 100;
   localparam int FCS_NS = 30;
   localparam int FCH_NS = 30;
   localparam int CPT_NS = 70;
   localparam int RFSH_INT_NS = 4000000;
   localparam int RFSH_ROWS = 256;
   localparam int PWRUP_NS = 100000;
   localparam int INIT_CYCLES = 8;
   localparam int CNT_W = 16;
   // least times round up
   localparam logic [CNT_W-1:0] ROW_HOLD_CYC =
      CNT_W'((ROW_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] RCD_CYC =
      CNT_W'((RCD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] ACCESS_CYC =
      CNT_W'((ROW_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1);
   localparam logic [CNT_W-1:0] CAS_CYC =
      CNT_W'((CAS_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] CWD_CYC =
      CNT_W'((CWD_NS + COL_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] HOLD_CYC =
      CNT_W'((COL_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] RAS_CYC =
      CNT_W'((RAS_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] PRE_CYC =
      CNT_W'((RAS_PRE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] FCS_CYC =
      CNT_W'((FCS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] FCH_CYC =
      CNT_W'((FCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] CPT_CYC =
      CNT_W'((CPT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   // longest interval less slack for a refresh held off behind an access, spread over all rows
   localparam int RFSH_SLACK_CYC = 1000;
   localparam int RFSH_EVERY_DEF = (RFSH_INT_NS / CLK_PERIOD_NS - RFSH_SLACK_CYC) / RFSH_ROWS;
   localparam int PWRUP_DEF = (PWRUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] INIT_CNT = 4'(INIT_CYCLES);
   // command codes
   localparam logic [1:0] CMD_READ = 2'h0;
   localparam logic [1:0] CMD_WRITE = 2'h1;
   localparam logic [1:0] CMD_RMW = 2'h2;
   localparam logic [1:0] CMD_TEST = 2'h3;
   typedef enum logic [3:0] {
      ST_PWRUP = 4'h0, ST_IDLE = 4'h1, ST_ROW = 4'h3, ST_COL = 4'h2,
      ST_ACC = 4'h6, ST_WR = 4'h7, ST_END = 4'h5, ST_PRE = 4'h4,
      ST_CBR = 4'hc, ST_CBRH = 4'hd, ST_TCP = 4'hf, ST_INIT = 4'he
   } drs_state_t;
endpackage
